/* src/nvss_ctrl.sv */
// Serial two-wire access, address counters and store/recall control of the nvSRAM
`timescale 1ns/1ps
// Overview of operation
// - Write guard high rejects all memory and register writes, counter holds.
// - Power fail with power-loss store enabled blocks access, stores if written.
// - Store busy pin pulled low while idle stores after delay if written.
// - Pin-requested store blocks memory for store time or while pin low.
// - Store busy pin driven low during any store.
// - After hardware or software store, pin driven high for release time.
// - Access stays blocked for lockout time after a store's release drive ends.
// - At power-up recall runs, access blocked, busy pin shows not ready.
// - Slave address bit zero selects write (0) or read (1).
// - Write runs until stop, repeated start or NACK; after NACK ignore SDA.
// - Slave address without a valid identifier is NACKed.
// - Write to protected memory NACKed after data, counter parked there.
// - Write to read-only control register NACKed, counter parked there.
// - Nonexistent address NACKed after address byte, counter unchanged.
// - Written byte committed after eighth bit, then ACKed.
// - Read drives data from counter address, wraps after last address.
// - Control burst read past last location or from command wraps to zero.
// - Memory counter increments per byte and wraps to zero.
// - Random read loads counter from write address phase before restart.
// - Block-protect field selects none, top quarter, upper half or all.
module nvss_ctrl import nvss_pkg::*; #(
	parameter int P_STORE_CYC = STORE_CYC,
	parameter int P_RECALL_CYC = RECALL_CYC,
	parameter logic [31:0] P_DEV_ID = DEV_ID_DEF
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic i_sda,
	output nvss_od_t o_sda,
	input wire logic i_store_busy_pin,
	output nvss_od_t o_store_busy_pin,
	input wire logic i_write_guard,
	input wire logic i_power_fail
);
	logic [4:0] sy1_r, sy2_r;
	logic scl_d_r, sda_d_r;
	logic scl_s, sda_s, hsb_low, wp_s, pf_s;
	logic rise, fall, start, stop;
	nvss_bus_st_t st_r, nxt_r, go_nxt;
	nvss_nv_st_t nv_r;
	logic [3:0] bcnt_r;
	logic [7:0] sh_r, hi_r, ctl_cnt_r, rd_byte, ctl_eff;
	logic oe_r, mack_r, sel_ctl_r, ack_nxt;
	logic [MEM_AW-1:0] mem_cnt_r;
	logic [7:0] mem [0:(1<<MEM_AW)-1];
	logic [7:0] sn [0:7];
	logic [1:0] bp_r, own_r;
	logic snl_r, as_en_r, dirty_r;
	logic [TMR_W-1:0] tmr_r;
	logic blocked, prot, mem_we, ctl_we, ld_rd, id_ok, ctl_ok, byte_done, fall9;
	logic cmd_store, cmd_recall;

	// Two-stage synchronisers for all pins
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			sy1_r <= 5'h1f;
			sy2_r <= 5'h1f;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
			own_r <= 2'h3;
		end else begin
			sy1_r <= {i_scl, i_sda, i_store_busy_pin, i_write_guard, i_power_fail};
			sy2_r <= sy1_r;
			scl_d_r <= sy2_r[4];
			sda_d_r <= sy2_r[3];
			own_r <= {own_r[0], o_store_busy_pin.oe}; // Echo of our own pin drive
		end
	end
	assign scl_s = sy2_r[4];
	assign sda_s = sy2_r[3];
	assign hsb_low = ~sy2_r[2] && !own_r[1];
	assign wp_s = sy2_r[1];
	assign pf_s = sy2_r[0];
	assign rise = scl_s & ~scl_d_r;
	assign fall = ~scl_s & scl_d_r;
	assign start = scl_s & scl_d_r & sda_d_r & ~sda_s;
	assign stop = scl_s & scl_d_r & ~sda_d_r & sda_s;
	assign byte_done = fall && bcnt_r == 4'h8 && st_r != ST_RD;
	assign fall9 = fall && bcnt_r == 4'h9;

	assign blocked = nv_r != NV_IDLE || pf_s || hsb_low;
	always_comb begin
		unique case (bp_r)
			BP_NONE: prot = 1'b0;
			BP_QTR: prot = mem_cnt_r >= PROT_QTR;
			BP_HALF: prot = mem_cnt_r >= PROT_HALF;
			default: prot = 1'b1;
		endcase
	end
	assign id_ok = sh_r[7:1] == MEM_SLV || sh_r[7:1] == CTL_SLV;
	assign ctl_ok = ctl_cnt_r == CTL_MCR || ctl_cnt_r == CTL_CMD ||
		(ctl_cnt_r >= CTL_SN_LO && ctl_cnt_r <= CTL_SN_HI && !snl_r);

	// Decision at the end of each received byte
	always_comb begin
		ack_nxt = 1'b0;
		go_nxt = ST_IGN;
		mem_we = 1'b0;
		ctl_we = 1'b0;
		if (byte_done) begin
			unique case (st_r)
				ST_DEV: begin
					if (id_ok && !blocked) begin
						ack_nxt = 1'b1;
						go_nxt = sh_r[0] ? ST_RD : (sh_r[7:1] == MEM_SLV ? ST_ADH : ST_ADL);
					end
				end
				ST_ADH: begin
					ack_nxt = 1'b1;
					go_nxt = ST_ADL;
				end
				ST_ADL: begin
					if (!sel_ctl_r || sh_r <= CTL_ID_HI || sh_r == CTL_CMD) begin
						ack_nxt = 1'b1;
						go_nxt = ST_WR;
					end
				end
				ST_WR: begin
					if (sel_ctl_r) begin
						ctl_we = !wp_s && ctl_ok;
					end else begin
						mem_we = !wp_s && !blocked && !prot;
					end
					ack_nxt = ctl_we | mem_we;
					go_nxt = ack_nxt ? ST_WR : ST_IGN;
				end
				default: ;
			endcase
		end
	end
	assign cmd_store = ctl_we && ctl_cnt_r == CTL_CMD && sh_r == CMD_STORE;
	assign cmd_recall = ctl_we && ctl_cnt_r == CTL_CMD && sh_r == CMD_RECALL;

	assign ctl_eff = ctl_cnt_r > CTL_ID_HI ? CTL_MCR : ctl_cnt_r;
	always_comb begin
		if (!sel_ctl_r) begin
			rd_byte = mem[mem_cnt_r];
		end else if (ctl_eff == CTL_MCR) begin
			rd_byte = 8'h00;
			rd_byte[MCR_SNL] = snl_r;
			rd_byte[MCR_BP+:2] = bp_r;
		end else if (ctl_eff <= CTL_SN_HI) begin
			rd_byte = sn[3'(ctl_eff - CTL_SN_LO)];
		end else begin
			rd_byte = P_DEV_ID[8 * (3 - int'(2'(ctl_eff - CTL_ID_LO)))+:8];
		end
	end
	assign ld_rd = fall9 && !blocked &&
		((st_r != ST_RD && nxt_r == ST_RD) || (st_r == ST_RD && mack_r));

	// Bus protocol state
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_r <= ST_IDLE;
			nxt_r <= ST_IDLE;
			bcnt_r <= 4'h0;
			sh_r <= 8'h00;
			hi_r <= 8'h00;
			oe_r <= 1'b0;
			mack_r <= 1'b0;
			sel_ctl_r <= 1'b0;
		end else if (start) begin
			st_r <= ST_DEV;
			bcnt_r <= 4'h0;
			oe_r <= 1'b0;
		end else if (stop) begin
			st_r <= ST_IDLE;
			oe_r <= 1'b0;
		end else if (st_r != ST_IDLE && st_r != ST_IGN) begin
			if (rise && st_r != ST_RD && bcnt_r < 4'h8) begin
				sh_r <= {sh_r[6:0], sda_s};
				bcnt_r <= bcnt_r + 4'h1;
			end else if (rise && st_r == ST_RD && bcnt_r == 4'h9) begin
				mack_r <= ~sda_s;
			end else if (fall && bcnt_r == 4'h8) begin
				bcnt_r <= 4'h9;
				oe_r <= st_r == ST_RD ? 1'b0 : ack_nxt;
				nxt_r <= st_r == ST_RD ? ST_RD : go_nxt;
				if (st_r == ST_DEV) begin
					sel_ctl_r <= sh_r[7:1] == CTL_SLV;
				end
				if (st_r == ST_ADH) begin
					hi_r <= sh_r;
				end
			end else if (fall9) begin
				if (ld_rd) begin
					oe_r <= ~rd_byte[7];
					sh_r <= {rd_byte[6:0], 1'b0};
					bcnt_r <= 4'h1;
					st_r <= ST_RD;
				end else begin
					oe_r <= 1'b0;
					bcnt_r <= 4'h0;
					st_r <= st_r == ST_RD ? ST_IGN : nxt_r;
				end
			end else if (fall && st_r == ST_RD && bcnt_r < 4'h8) begin
				oe_r <= ~sh_r[7];
				sh_r <= {sh_r[6:0], 1'b0};
				bcnt_r <= bcnt_r + 4'h1;
			end
		end
	end
	assign o_sda.out = 1'b0;
	assign o_sda.oe = oe_r;
	// Address counters
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mem_cnt_r <= '0;
			ctl_cnt_r <= CTL_MCR;
		end else if (byte_done && st_r == ST_ADL && ack_nxt) begin
			if (sel_ctl_r) begin
				ctl_cnt_r <= sh_r;
			end else begin
				mem_cnt_r <= {hi_r, sh_r};
			end
		end else if (mem_we || (ld_rd && !sel_ctl_r)) begin
			mem_cnt_r <= mem_cnt_r + 16'h0001;
		end else if (ctl_we && ctl_cnt_r != CTL_CMD) begin
			ctl_cnt_r <= ctl_cnt_r + 8'h01;
		end else if (ld_rd) begin
			ctl_cnt_r <= ctl_eff == CTL_ID_HI ? CTL_MCR : ctl_eff + 8'h01;
		end
	end

	always_ff @(posedge i_clk) begin
		if (mem_we) begin
			mem[mem_cnt_r] <= sh_r;
		end
		if (ctl_we && ctl_cnt_r >= CTL_SN_LO && ctl_cnt_r <= CTL_SN_HI) begin
			sn[3'(ctl_cnt_r - CTL_SN_LO)] <= sh_r;
		end
	end

	// Control register and command state
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			bp_r <= BP_NONE;
			snl_r <= 1'b0;
			as_en_r <= 1'b1;
		end else if (ctl_we && ctl_cnt_r == CTL_MCR) begin
			bp_r <= sh_r[MCR_BP+:2];
			snl_r <= snl_r | sh_r[MCR_SNL];
		end else if (ctl_we && sh_r == CMD_ASENB && ctl_cnt_r == CTL_CMD) begin
			as_en_r <= 1'b1;
		end else if (ctl_we && sh_r == CMD_ASDISB && ctl_cnt_r == CTL_CMD) begin
			as_en_r <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			dirty_r <= 1'b0;
		end else if (mem_we) begin
			dirty_r <= 1'b1;
		end else if (nv_r == NV_STORE || nv_r == NV_RECALL) begin
			dirty_r <= 1'b0;
		end
	end

	// Store, recall and lockout sequencing
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			nv_r <= NV_RECALL;
			tmr_r <= TMR_W'(P_RECALL_CYC - 1);
		end else begin
			if (tmr_r != '0) begin
				tmr_r <= tmr_r - TMR_W'(1);
			end
			unique case (nv_r)
				NV_RECALL: if (tmr_r == '0) nv_r <= NV_IDLE;
				NV_IDLE: begin
					if (pf_s && as_en_r && dirty_r) begin
						nv_r <= NV_STORE;
						tmr_r <= TMR_W'(P_STORE_CYC - 1);
					end else if (cmd_store) begin
						nv_r <= NV_STORE;
						tmr_r <= TMR_W'(P_STORE_CYC - 1);
					end else if (cmd_recall) begin
						nv_r <= NV_RECALL;
						tmr_r <= TMR_W'(P_RECALL_CYC - 1);
					end else if (hsb_low && !pf_s) begin
						nv_r <= NV_REQ;
						tmr_r <= TMR_W'(REQ_CYC - 1);
					end
				end
				NV_REQ: begin
					if (tmr_r == '0) begin
						nv_r <= dirty_r ? NV_STORE : NV_IDLE;
						tmr_r <= TMR_W'(P_STORE_CYC - 1);
					end
				end
				NV_STORE: begin
					if (tmr_r == '0) begin
						nv_r <= NV_REL;
						tmr_r <= TMR_W'(REL_CYC - 1);
					end
				end
				NV_REL: begin
					if (tmr_r == '0) begin
						nv_r <= NV_LOCK;
						tmr_r <= TMR_W'(LOCK_CYC - 1);
					end
				end
				NV_LOCK: if (tmr_r == '0) nv_r <= NV_IDLE;
			endcase
		end
	end
	assign o_store_busy_pin.out = nv_r == NV_REL;
	assign o_store_busy_pin.oe = nv_r == NV_STORE || nv_r == NV_RECALL || nv_r == NV_REL;

	localparam int REQ_LO = REQ_CYC, REQ_HI = REQ_CYC + 1;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence rel_drive;
		(o_store_busy_pin.oe && o_store_busy_pin.out)[*2] ##1 !o_store_busy_pin.oe;
	endsequence
	sequence lock_hold;
		(nv_r == NV_LOCK)[*5] ##1 nv_r == NV_IDLE;
	endsequence
	chk_wp_no_write: assert property (byte_done && st_r == ST_WR && wp_s |=> $stable(rd_byte) && $stable(bp_r)) else $error("write while guarded");
	chk_wp_cnt_hold: assert property (byte_done && st_r == ST_WR && wp_s |=> $stable(mem_cnt_r) && !oe_r) else $error("guarded write moved counter");
	chk_pf_store: assert property (nv_r == NV_IDLE && pf_s && as_en_r && dirty_r |=> nv_r == NV_STORE) else $error("no store on power fail");
	chk_pin_req: assert property (nv_r == NV_IDLE && hsb_low && !pf_s && dirty_r && !cmd_store && !cmd_recall |-> ##[REQ_LO:REQ_HI] nv_r == NV_STORE) else $error("pin store late");
	chk_busy_low: assert property (nv_r == NV_STORE |-> o_store_busy_pin.oe && !o_store_busy_pin.out) else $error("busy pin not low");
	chk_release_drive: assert property (nv_r == NV_STORE && tmr_r == '0 |=> rel_drive) else $error("release drive wrong");
	chk_lockout_time: assert property ($rose(nv_r == NV_LOCK) |-> lock_hold) else $error("lockout length wrong");
	chk_recall_boot: assert property ($fell(i_rst) |-> nv_r == NV_RECALL && o_store_busy_pin.oe) else $error("no recall at power-up");
	chk_bad_id_nack: assert property (byte_done && st_r == ST_DEV && (!id_ok || blocked) |=> !oe_r ##1 1) else $error("bad address acked");
	chk_mem_wrap: assert property (mem_we && mem_cnt_r == 16'hffff |=> mem_cnt_r == 16'h0000) else $error("memory counter no wrap");
	chk_ctl_wrap: assert property (ld_rd && sel_ctl_r && ctl_cnt_r == CTL_CMD |=> ctl_cnt_r == CTL_SN_LO) else $error("command read no wrap");
endmodule

/* src/nvss_pkg.sv */
// Constants, types and timing for the serial nvSRAM access and store control
package nvss_pkg;
	localparam int CLK_NS = 100;
	localparam int T_REQ_DELAY_NS = 1000;
	localparam int T_STORE_NS = 8000000;
	localparam int T_RELEASE_NS = 200;
	localparam int T_LOCKOUT_NS = 500;
	localparam int T_RECALL_NS = 20000000;
	localparam int REQ_CYC = (T_REQ_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int STORE_CYC = (T_STORE_NS + CLK_NS - 1) / CLK_NS;
	localparam int REL_CYC = (T_RELEASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int LOCK_CYC = (T_LOCKOUT_NS + CLK_NS - 1) / CLK_NS;
	localparam int RECALL_CYC = (T_RECALL_NS + CLK_NS - 1) / CLK_NS;
	localparam int TMR_W = 24;
	localparam int MEM_AW = 16;
	// Slave identifiers, arbitrary values
	localparam logic [6:0] MEM_SLV = 7'h50;
	localparam logic [6:0] CTL_SLV = 7'h18;
	localparam logic [7:0] CTL_MCR = 8'h00;
	localparam logic [7:0] CTL_SN_LO = 8'h01;
	localparam logic [7:0] CTL_SN_HI = 8'h08;
	localparam logic [7:0] CTL_ID_LO = 8'h09;
	localparam logic [7:0] CTL_ID_HI = 8'h0c;
	localparam logic [7:0] CTL_CMD = 8'haa;
	localparam int MCR_SNL = 6;
	localparam int MCR_BP = 2;
	localparam logic [7:0] CMD_STORE = 8'h3c;
	localparam logic [7:0] CMD_RECALL = 8'h60;
	localparam logic [7:0] CMD_ASENB = 8'h59;
	localparam logic [7:0] CMD_ASDISB = 8'h19;
	localparam logic [1:0] BP_NONE = 2'h0;
	localparam logic [1:0] BP_QTR = 2'h1;
	localparam logic [1:0] BP_HALF = 2'h2;
	localparam logic [15:0] PROT_QTR = 16'hc000;
	localparam logic [15:0] PROT_HALF = 16'h8000;
	// Arbitrary identification value
	localparam logic [31:0] DEV_ID_DEF = 32'h0000_0001;
	typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_ADH, ST_ADL, ST_WR, ST_RD, ST_IGN} nvss_bus_st_t;
	typedef enum logic [2:0] {NV_RECALL, NV_IDLE, NV_REQ, NV_STORE, NV_REL, NV_LOCK} nvss_nv_st_t;
	typedef struct packed {
		logic out;
		logic oe;
	} nvss_od_t;
endpackage

/* test/nvss_ctrl_bench.sv */
// Self-checking bench for the serial nvSRAM access and store control
`timescale 1ns/1ps
module nvss_ctrl_bench import nvss_pkg::*;;
	// Arbitrary identification value
	localparam logic [31:0] DEVID = 32'h1234_5678;
	localparam logic [7:0] MW = {MEM_SLV, 1'b0};
	localparam logic [7:0] MR = {MEM_SLV, 1'b1};
	localparam logic [7:0] CW = {CTL_SLV, 1'b0};
	localparam logic [7:0] CR = {CTL_SLV, 1'b1};
	localparam logic [1:0] BPT [6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
	localparam logic [15:0] PAT [6] = '{16'hc000, 16'hbfff, 16'h8000, 16'h7fff, 16'h0, 16'hffff};
	logic i_clk = 0;
	logic i_rst, i_write_guard, i_power_fail, b_low, m_scl_low, m_sda_low;
	nvss_od_t o_sda;
	nvss_od_t o_store_busy_pin;
	logic [7:0] q[$];
	logic [31:0] seed = 32'd42028;
	int fails = 0;
	int comparisons = 0;
	int cyc = 0;
	wire sda = !(m_sda_low || (o_sda.oe && !o_sda.out));
	wire store_busy_pin = o_store_busy_pin.oe ? o_store_busy_pin.out : !b_low;
	wire [1:0] hs = {o_store_busy_pin.oe, o_store_busy_pin.out};
	always #50 i_clk = ~i_clk;
	nvss_ctrl #(.P_STORE_CYC(200), .P_RECALL_CYC(200), .P_DEV_ID(DEVID)) uut (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_scl(!m_scl_low),
		.i_sda(sda),
		.o_sda(o_sda),
		.i_store_busy_pin(store_busy_pin),
		.o_store_busy_pin(o_store_busy_pin),
		.i_write_guard(i_write_guard),
		.i_power_fail(i_power_fail)
	);
	nvss_master m (.i_sda(sda), .o_scl_low(m_scl_low), .o_sda_low(m_sda_low));
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: expected %h, got %h", $time, e, g);
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d, fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic tx(input logic [7:0] d, input logic rd, nak, input logic [7:0] e);
		q.push_back(e);
		m.xfer(d, rd, nak);
	endtask
	task automatic adr(input logic [7:0] id, input logic [15:0] a, input logic two, nk);
		m.start();
		tx(id, 0, 0, 0);
		if (two) tx(a[15:8], 0, 0, 0);
		tx(a[7:0], 0, 0, {7'h0, nk});
	endtask
	task automatic step();
		@(posedge i_clk);
		#1;
	endtask
	task automatic wt(input logic [1:0] v, input int n);
		for (int i = 0; i < n && hs !== v; i++) step();
		chk({6'h0, v}, {6'h0, hs});
	endtask
	task automatic idle();
		for (int i = 0; i < 400 && o_store_busy_pin.oe !== 1'b0; i++) step();
		chk(8'h0, {7'h0, o_store_busy_pin.oe});
		repeat (8) step();
	endtask
	// Results from the master are matched in order against the notes
	always @(m.got) chk(q.pop_front(), m.res);
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			summarize();
		end
	end
	initial begin
		logic [7:0] a, b, c;
		int k;
		logic x;
		i_rst = 1;
		i_write_guard = 0;
		i_power_fail = 0;
		b_low = 0;
		repeat (5) @(posedge i_clk);
		#1 i_rst = 0;
		wt(2'b10, 4);
		m.start();
		tx(MW, 0, 0, 1);
		m.stop();
		idle();
		m.start();
		tx(8'h66, 0, 0, 1);
		m.stop();
		a = rnd();
		b = rnd();
		c = rnd();
		adr(MW, 16'hfffe, 1, 0);
		tx(a, 0, 0, 0);
		tx(b, 0, 0, 0);
		tx(c, 0, 0, 0);
		m.stop();
		adr(MW, 16'hfffe, 1, 0);
		m.start();
		tx(MR, 0, 0, 0);
		tx(8'hff, 1, 0, a);
		tx(8'hff, 1, 0, b);
		tx(8'hff, 1, 1, c);
		m.stop();
		step();
		i_write_guard = 1;
		adr(MW, 16'h0000, 1, 0);
		tx(rnd(), 0, 0, 1);
		m.stop();
		step();
		i_write_guard = 0;
		adr(MW, 16'h0000, 1, 0);
		for (int i = 0; i < 6; i++) m.bitx(1'b0, x);
		m.stop();
		adr(MW, 16'h0000, 1, 0);
		m.start();
		tx(MR, 0, 0, 0);
		tx(8'hff, 1, 1, c);
		m.stop();
		for (int i = 0; i < 6; i++) begin
			adr(CW, 16'h0000, 0, 0);
			tx({4'h0, BPT[i], 2'h0}, 0, 0, 0);
			m.stop();
			adr(MW, PAT[i], 1, 0);
			tx(rnd(), 0, 0, {7'h0, ~i[0]});
			m.stop();
		end
		adr(CW, 16'h0009, 0, 0);
		tx(rnd(), 0, 0, 1);
		tx(rnd(), 0, 0, 1);
		m.stop();
		adr(CW, 16'h000d, 0, 1);
		tx(8'h00, 0, 0, 1);
		m.stop();
		m.start();
		tx(CR, 0, 0, 0);
		for (int i = 3; i >= 0; i--) tx(8'hff, 1, 0, DEVID[i*8 +: 8]);
		tx(8'hff, 1, 1, 8'h00);
		m.stop();
		adr(CW, 16'h00aa, 0, 0);
		m.start();
		tx(CR, 0, 0, 0);
		tx(8'hff, 1, 1, 8'h00);
		m.stop();
		step();
		b_low = 1;
		wt(2'b10, 30);
		b_low = 0;
		m.start();
		tx(MW, 0, 0, 1);
		m.stop();
		wt(2'b11, 300);
		k = 0;
		while (hs === 2'b11 && k < 20) begin
			step();
			k++;
		end
		chk(8'(REL_CYC), k[7:0]);
		idle();
		b_low = 1;
		repeat (30) step();
		chk(8'h0, {7'h0, o_store_busy_pin.oe});
		b_low = 0;
		idle();
		adr(CW, 16'h00aa, 0, 0);
		tx(CMD_STORE, 0, 0, 0);
		m.stop();
		wt(2'b11, 300);
		idle();
		adr(MW, 16'h1234, 1, 0);
		tx(rnd(), 0, 0, 0);
		m.stop();
		step();
		i_power_fail = 1;
		wt(2'b10, 6);
		m.start();
		tx(MW, 0, 0, 1);
		m.stop();
		step();
		i_power_fail = 0;
		summarize();
	end
endmodule

/* test/nvss_master.sv */
// Bus master model: open-drain clock and data, clock still between frames
`timescale 1ns/1ps
module nvss_master (
	input wire logic i_sda,
	output logic o_scl_low,
	output logic o_sda_low
);
	logic [7:0] res;
	event got;
	initial begin
		o_scl_low = 0;
		o_sda_low = 0;
	end
	task automatic bitx(input logic b, output logic r);
		#100 o_sda_low = !b;
		#400 o_scl_low = 0;
		#300 r = i_sda;
		o_scl_low = 1;
	endtask
	task automatic start();
		#100 o_sda_low = 0;
		#400 o_scl_low = 0;
		#300 o_sda_low = 1;
		#300 o_scl_low = 1;
	endtask
	task automatic stop();
		#100 o_sda_low = 1;
		#400 o_scl_low = 0;
		#300 o_sda_low = 0;
		#300;
	endtask
	// A read releases data and answers with nak on the ninth clock
	task automatic xfer(input logic [7:0] d, input logic rd, input logic nak);
		logic [7:0] v;
		logic a;
		for (int i = 7; i >= 0; i--) bitx(rd | d[i], v[i]);
		bitx(rd ? nak : 1'b1, a);
		res = rd ? v : {7'h0, a};
		->got;
	endtask
endmodule
